/* File: inc/cie_consts.vh */
// named constants for the channel interrupt-exit and check block
`ifndef CIE_CONSTS_VH
`define CIE_CONSTS_VH

// avalon register byte offsets
`define CIE_OFS_CTRL 5'h00
`define CIE_OFS_START 5'h04
`define CIE_OFS_STATUS 5'h08
`define CIE_OFS_COUNT 5'h0c
`define CIE_OFS_MODE 5'h10
`define CIE_CTRL_RUN 0
`define CIE_STAT_ATTN 2

// preset interrupt locations (octal 42 and 43)
`define CIE_INT_LOC1 15'h0022
`define CIE_INT_LOC2 15'h0023

// machine-cycle times
`define CIE_T_RST 4'h2
`define CIE_T_LOAD 4'h7
`define CIE_T_CCRST 4'ha
`define CIE_T_LAST 4'hb

// storage-bus field positions (position p sits at index 35-p)
`define CIE_OP_HI 35
`define CIE_OP_LO 32
`define CIE_POS19 16
`define CIE_POS18 17
`define CIE_WC_HI 31
`define CIE_WC_LO 18
`define CIE_ADR_HI 14
`define CIE_ADR_LO 0
`define CIE_MCR_HI 6

// opcodes: {positions S,1,2,3, position 19}
`define CIE_OP_LIP 5'h02
`define CIE_OP_TDC 5'h04
`define CIE_OP_CTL 5'h08
`define CIE_OP_CONTROL_WRITE_CMD 5'h09
`define CIE_OP_CONTROL_READ_CMD 5'h0a
`define CIE_OP_SNS 5'h0b
`define CIE_OP_COPY_PROCEED_CMD 5'h0c
`define CIE_OP_COPY_DISCONNECT_CMD 5'h0e
`define CIE_OP_XFER 3'h4
`define CIE_OP_IFACE 3'h2
`define CIE_OP_COPY 3'h3
`define CIE_OP_ICC 5'h18
`define CIE_OP_SAR 5'h1a

`endif

/* File: rtl/cie_channel_exit.v */
// channel interrupt exit, transfer, indirect addressing and check logic
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cie_consts.vh"

// Summary of operation
// RL1 - interrupt stores command counter at location 42
// RL2 - leave counter cycle clears non-attention checks
// RL3 - leave command cycle clears interrupt, starts step one
// RL4 - step one forces preset location onto address
// RL5 - fetch reloads registers, sets step two at 7
// RL6 - step two suppresses operation decoding
// RL7 - closing command cycle transfers to address counter
// RL8 - pending attention held for one further command
// RL9 - leave-and-jump clears non-attention checks, acts as transfer
// RL10 - multiplexor decodes transfer, retains priority
// RL11 - transfer blocks loads, reloads command counter
// RL12 - bit 18 requests immediate indirect fetch
// RL13 - indirect fetch reloads only address counter
// RL14 - counter cycle waits for indirect fetch end
// RL15 - zero insert-count copies mode register to assembly
// RL16 - write: unrefilled data register sets data check
// RL17 - read: full word moves to data register
// RL18 - read demand finds unstored word, sets check
// RL19 - checks interrupt, blocked inside interrupt program
// RL20 - control commands free, copies only with data
// RL21 - sense needs copies, sequences end with disconnect
// RL22 - transfers between copy-proceeds raise no check
// RL23 - sequence check interrupts and blocks further checks
module cie_channel_exit #(
  parameter AW = 5
) (
  input wire mclk,
  input wire rstn,
  input wire [AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire bcw_req,
  output wire bdw_req,
  input wire bcw_grant,
  input wire bdw_grant,
  input wire [35:0] sb_data,
  output reg [35:0] sb_wdata,
  output reg sb_we,
  input wire retain_pri,
  input wire [14:0] mux_addr,
  output reg [14:0] mar_out,
  output reg mar_drive,
  input wire adp_demand,
  input wire adp_word_taken,
  input wire adp_attention,
  input wire [35:0] adp_data,
  output reg [35:0] adp_wdata,
  output wire io_write,
  output wire io_read
);

  // one-hot cycle states
  localparam ST_IDLE = 7'h01;
  localparam ST_BCWQ = 7'h02;
  localparam ST_BDWQ = 7'h04;
  localparam ST_BCW = 7'h08;
  localparam ST_BDW = 7'h10;
  localparam ST_CCC = 7'h20;
  localparam ST_CMD = 7'h40;

  reg [6:0] state_reg;
  reg [3:0] tcnt_reg;
  reg [14:0] cc_reg;
  reg [14:0] ac_reg;
  reg [13:0] wc_reg;
  reg [4:0] op_reg;
  reg [35:0] dr_reg;
  reg dr_loaded_reg;
  reg intr_reg;
  reg step1_reg;
  reg step2_reg;
  reg int1_reg;
  reg int2_reg;
  reg tch_reg;
  reg ind_reg;
  reg sar_reg;
  reg io_chk_reg;
  reg seq_chk_reg;
  reg attn_reg;
  reg attn_hold_reg;
  reg prep_reg;
  reg after_cs_reg;
  reg prev_if_reg;
  reg wr_mode_reg;
  reg rd_mode_reg;
  reg run_reg;
  reg ack_reg;
  reg [6:0] mcr_reg;
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg [2:0] last_reg;
  reg [35:0] data_meta_reg;
  reg [35:0] data_sync_reg;

  wire bus_req = avs_read | avs_write;
  wire bus_wr = avs_write & ack_reg & avs_byteenable[0]; // writes land at the answer edge
  wire start_pulse = bus_wr & (avs_address == `CIE_OFS_START);
  wire attn_clr = bus_wr & (avs_address == `CIE_OFS_STATUS) &
    avs_writedata[`CIE_STAT_ATTN];
  wire [4:0] sb_op = {sb_data[`CIE_OP_HI:`CIE_OP_LO], sb_data[`CIE_POS19]};
  wire chk_gate = ~intr_reg;
  wire demand_rise = sync_reg[0] & ~last_reg[0];
  wire taken_rise = sync_reg[1] & ~last_reg[1];
  wire attn_rise = sync_reg[2] & ~last_reg[2];
  wire is_if = (op_reg[4:2] == `CIE_OP_IFACE);
  wire is_copy = (op_reg[4:2] == `CIE_OP_COPY);
  wire decode_ok = ~step2_reg & ~step1_reg;
  wire at_last = (tcnt_reg == `CIE_T_LAST);
  wire sb_xfer = (sb_op[4:2] == `CIE_OP_XFER);
  wire data_need = (rd_mode_reg & dr_loaded_reg) | (wr_mode_reg & ~dr_loaded_reg);
  wire int_pend = io_chk_reg | seq_chk_reg | (attn_reg & ~attn_hold_reg);
  wire seq_err = (is_copy & ~prep_reg) | (is_if & prev_if_reg) |
    (after_cs_reg & ~is_copy & (op_reg != `CIE_OP_TDC));

  assign avs_waitrequest = bus_req & ~ack_reg;
  assign bcw_req = state_reg[1];
  assign bdw_req = state_reg[2];
  assign io_write = wr_mode_reg;
  assign io_read = rd_mode_reg;

  // bus slave: one wait cycle, read data registered for the answer edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      run_reg <= 1'b0;
      mcr_reg <= 7'h00;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        case (avs_address)
          `CIE_OFS_CTRL: avs_readdata <= {31'h0000_0000, run_reg};
          `CIE_OFS_STATUS: avs_readdata <= {10'h000, state_reg, op_reg, wr_mode_reg,
            rd_mode_reg, step2_reg, step1_reg, intr_reg, attn_hold_reg, dr_loaded_reg,
            attn_reg, seq_chk_reg, io_chk_reg};
          `CIE_OFS_COUNT: avs_readdata <= {1'b0, ac_reg, 1'b0, cc_reg};
          `CIE_OFS_MODE: avs_readdata <= {25'h000_0000, mcr_reg};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (bus_wr & (avs_address == `CIE_OFS_CTRL)) begin
        run_reg <= avs_writedata[`CIE_CTRL_RUN];
      end
      if (start_pulse) begin
        run_reg <= 1'b1;
      end
      if (bus_wr & (avs_address == `CIE_OFS_MODE)) begin
        mcr_reg <= avs_writedata[`CIE_MCR_HI:0];
      end
    end
  end

  // adapter pins pass two flops before anything looks at them
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      last_reg <= 3'h0;
      data_meta_reg <= 36'h0_0000_0000;
      data_sync_reg <= 36'h0_0000_0000;
    end else begin
      meta_reg <= {adp_attention, adp_word_taken, adp_demand};
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      data_meta_reg <= adp_data;
      data_sync_reg <= data_meta_reg;
    end
  end

  // address presented for the requested storage cycle
  always @* begin
    mar_drive = 1'b0;
    mar_out = cc_reg;
    if (state_reg[1] | state_reg[3]) begin
      mar_drive = ~retain_pri; // remote required blocks counter gating, see RL10
      if (step1_reg) begin
        mar_out = `CIE_INT_LOC1; // see RL4
      end else if (int2_reg) begin
        mar_out = `CIE_INT_LOC2;
      end
    end else if (state_reg[2] | state_reg[4]) begin
      mar_drive = 1'b1;
      mar_out = int1_reg ? `CIE_INT_LOC1 : ac_reg; // see RL1
    end
  end

  // cycle sequencer, counters, command execution and check triggers
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      tcnt_reg <= 4'h0;
      cc_reg <= 15'h0000;
      ac_reg <= 15'h0000;
      wc_reg <= 14'h0000;
      op_reg <= 5'h00;
      dr_reg <= 36'h0_0000_0000;
      dr_loaded_reg <= 1'b0;
      adp_wdata <= 36'h0_0000_0000;
      sb_wdata <= 36'h0_0000_0000;
      sb_we <= 1'b0;
      intr_reg <= 1'b0;
      step1_reg <= 1'b0;
      step2_reg <= 1'b0;
      int1_reg <= 1'b0;
      int2_reg <= 1'b0;
      tch_reg <= 1'b0;
      ind_reg <= 1'b0;
      sar_reg <= 1'b0;
      io_chk_reg <= 1'b0;
      seq_chk_reg <= 1'b0;
      attn_reg <= 1'b0;
      attn_hold_reg <= 1'b0;
      prep_reg <= 1'b0;
      after_cs_reg <= 1'b0;
      prev_if_reg <= 1'b0;
      wr_mode_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
    end else begin
      sb_we <= 1'b0;
      tcnt_reg <= tcnt_reg + 4'h1;
      case (state_reg)
        ST_IDLE: begin
          tcnt_reg <= 4'h0;
          if (start_pulse) begin
            cc_reg <= avs_writedata[`CIE_ADR_HI:`CIE_ADR_LO];
            state_reg <= ST_BCWQ;
          end else if (run_reg & data_need) begin
            state_reg <= ST_BDWQ;
          end
        end
        ST_BCWQ: begin
          tcnt_reg <= 4'h0;
          if (bcw_grant) begin
            state_reg <= ST_BCW;
          end
        end
        ST_BDWQ: begin
          tcnt_reg <= 4'h0;
          if (bdw_grant) begin
            state_reg <= ST_BDW;
          end
        end
        ST_BCW: begin
          if (tcnt_reg == `CIE_T_RST) begin
            int2_reg <= 1'b0;
            ac_reg <= 15'h0000;
            // transfer and leave-and-jump are seen by the same decode, see RL11
            if (decode_ok & ~ind_reg & sb_xfer) begin
              tch_reg <= 1'b1;
              if (sb_data[`CIE_POS19]) begin
                intr_reg <= 1'b0; // see RL9
                io_chk_reg <= 1'b0;
                seq_chk_reg <= 1'b0;
                attn_hold_reg <= 1'b1; // see RL8
              end
            end else if (~ind_reg) begin
              op_reg <= 5'h00;
              wc_reg <= 14'h0000;
            end
          end
          if (tcnt_reg == `CIE_T_LOAD) begin
            ac_reg <= sb_data[`CIE_ADR_HI:`CIE_ADR_LO];
            // indirect fetch keeps the first operation and count, see RL13
            if (~tch_reg & ~ind_reg) begin
              op_reg <= sb_op;
              wc_reg <= sb_data[`CIE_WC_HI:`CIE_WC_LO];
            end
            if (step1_reg) begin
              step2_reg <= 1'b1; // see RL5
            end
          end
          if (tch_reg & (tcnt_reg == `CIE_T_CCRST)) begin
            cc_reg <= 15'h0000; // see RL11
          end
          if (at_last) begin
            if (tch_reg) begin
              tch_reg <= 1'b0;
              cc_reg <= mux_addr; // see RL11
              state_reg <= ST_BCWQ; // retained priority fetch at the target
            end else if (decode_ok & ~ind_reg & sb_data[`CIE_POS18]) begin
              ind_reg <= 1'b1; // see RL12
              state_reg <= ST_BCWQ;
            end else begin
              ind_reg <= 1'b0;
              state_reg <= ST_CCC; // counter cycle once no transfer or indirect fetch is pending, see RL14
            end
          end
        end
        ST_CCC: begin
          if (at_last) begin
            cc_reg <= cc_reg + 15'h0001;
            if (decode_ok & (op_reg == `CIE_OP_LIP)) begin
              io_chk_reg <= 1'b0; // attentions survive, see RL2
              seq_chk_reg <= 1'b0;
            end
            state_reg <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (at_last) begin
            if (attn_hold_reg) begin
              attn_hold_reg <= 1'b0; // one command has now run, see RL8
            end
            if (step2_reg) begin
              step1_reg <= 1'b0; // see RL7
              step2_reg <= 1'b0;
              cc_reg <= ac_reg; // see RL7
              attn_hold_reg <= 1'b1; // see RL8
            end else begin
              // decoding is suppressed while step two is active, see RL6
              case (op_reg)
                `CIE_OP_LIP: begin
                  intr_reg <= 1'b0; // see RL3
                  step1_reg <= 1'b1;
                end
                `CIE_OP_TDC: begin
                  if (wc_reg != 14'h0000) begin
                    wc_reg <= wc_reg - 14'h0001;
                    cc_reg <= ac_reg;
                  end
                end
                `CIE_OP_ICC: begin
                  if (wc_reg == 14'h0000) begin
                    adp_wdata[`CIE_MCR_HI:0] <= mcr_reg; // see RL15
                  end
                end
                `CIE_OP_SAR: begin
                  sar_reg <= 1'b1; // see RL15
                end
                `CIE_OP_CONTROL_WRITE_CMD: begin
                  rd_mode_reg <= 1'b0;
                  wr_mode_reg <= 1'b0;
                end
                `CIE_OP_CONTROL_READ_CMD: begin
                  rd_mode_reg <= 1'b0;
                  wr_mode_reg <= 1'b0;
                end
                `CIE_OP_COPY_PROCEED_CMD: begin
                  wr_mode_reg <= wr_mode_reg | (~rd_mode_reg & prep_reg);
                end
                `CIE_OP_COPY_DISCONNECT_CMD: begin
                  wr_mode_reg <= 1'b0;
                  rd_mode_reg <= 1'b0;
                end
                default: begin
                  wc_reg <= wc_reg;
                end
              endcase
              // command order tracking; transfers between copies pass, see RL22
              prev_if_reg <= is_if & (op_reg != `CIE_OP_CTL);
              after_cs_reg <= (op_reg == `CIE_OP_COPY_PROCEED_CMD) | (op_reg == `CIE_OP_SNS) |
                (after_cs_reg & (op_reg == `CIE_OP_TDC));
              if ((op_reg == `CIE_OP_CONTROL_WRITE_CMD) | (op_reg == `CIE_OP_CONTROL_READ_CMD) |
                  (op_reg == `CIE_OP_SNS)) begin
                prep_reg <= 1'b1;
              end else if (~is_copy & (op_reg != `CIE_OP_TDC)) begin
                prep_reg <= 1'b0;
              end else if (op_reg == `CIE_OP_COPY_DISCONNECT_CMD) begin
                prep_reg <= 1'b0;
              end
              if (seq_err & chk_gate) begin
                seq_chk_reg <= 1'b1; // see RL23
              end
            end
            // pending checks, and an order error found now, go to the store, see RL19, RL23
            if (~step2_reg & chk_gate & (int_pend | seq_err) & (op_reg != `CIE_OP_LIP)) begin
              int1_reg <= 1'b1;
              state_reg <= ST_BDWQ;
            end else if (~step2_reg & (op_reg == `CIE_OP_SAR)) begin
              state_reg <= ST_BDWQ;
            end else if (run_reg | step1_reg) begin
              state_reg <= data_need ? ST_BDWQ : ST_BCWQ; // see RL3
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_BDW: begin
          if (tcnt_reg == `CIE_T_LOAD) begin
            if (int1_reg) begin
              sb_wdata <= {21'h00_0000, cc_reg}; // see RL1
              sb_we <= 1'b1;
            end else if (sar_reg) begin
              sb_wdata <= adp_wdata;
              sb_we <= 1'b1;
            end else if (rd_mode_reg & dr_loaded_reg) begin
              sb_wdata <= dr_reg; // stores the word, see RL17
              sb_we <= 1'b1;
              dr_loaded_reg <= 1'b0;
            end else if (wr_mode_reg & ~dr_loaded_reg) begin
              dr_reg <= sb_data;
              dr_loaded_reg <= 1'b1;
            end
          end
          if (at_last) begin
            if (int1_reg) begin
              int1_reg <= 1'b0;
              int2_reg <= 1'b1;
              intr_reg <= 1'b1;
            end
            sar_reg <= 1'b0;
            state_reg <= (run_reg | int1_reg) ? ST_BCWQ : ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      // write: refill the assembly word; a stale data register is lost data
      if (wr_mode_reg & taken_rise) begin
        if (dr_loaded_reg) begin
          adp_wdata <= dr_reg;
          dr_loaded_reg <= 1'b0;
        end else if (chk_gate) begin
          io_chk_reg <= 1'b1; // see RL16
        end
      end
      // read: each demand edge replaces the data register word
      if (rd_mode_reg & demand_rise) begin
        dr_reg <= data_sync_reg; // see RL17
        dr_loaded_reg <= 1'b1;
        if (dr_loaded_reg & chk_gate) begin
          io_chk_reg <= 1'b1; // see RL18
        end
      end
      // read mode follows a prepared copy whose previous command was no interface command other than CTL
      if ((state_reg == ST_CMD) & at_last & ~step2_reg & (op_reg == `CIE_OP_COPY_PROCEED_CMD) &
          prep_reg & ~wr_mode_reg) begin
        rd_mode_reg <= rd_mode_reg | ~prev_if_reg;
      end
      // attention set wins over a software clear
      if (attn_clr) begin
        attn_reg <= 1'b0;
      end
      if (attn_rise & chk_gate) begin
        attn_reg <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/cie_channel_exit_properties.sv */
// port-level assertions for the channel exit block
`timescale 1ns/1ps
`default_nettype none
module cie_exit_props #(
  parameter int AW = 5
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bcw_req,
  input wire logic bdw_req,
  input wire logic bcw_grant,
  input wire logic bdw_grant,
  input wire logic sb_we,
  input wire logic retain_pri,
  input wire logic mar_drive,
  input wire logic io_write,
  input wire logic io_read
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // bus answer and reset quiet
  a_reset_quiet: assert property ($rose(rstn) |-> !bcw_req && !bdw_req && !sb_we)
    else $error("request active right after reset");
  a_bus_answer: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in second cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h14
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  // storage requests stay up until granted, stores are single pulses
  a_bcw_hold: assert property (bcw_req && !bcw_grant |=> bcw_req)
    else $error("word cycle request dropped");
  a_bdw_hold: assert property (bdw_req && !bdw_grant |=> bdw_req)
    else $error("data cycle request dropped");
  a_store_pulse: assert property (sb_we |=> !sb_we)
    else $error("store strobe too long");
  a_store_time: assert property ($rose(sb_we) |-> $past(bdw_grant, 9) || $past(bdw_grant, 10))
    else $error("store strobe off its cycle time");
  // retained cycles take the multiplexor address and chain a second fetch
  a_retain_block: assert property (retain_pri |-> !mar_drive)
    else $error("address driven under retain");
  a_retain_next: assert property ($rose(retain_pri) |-> ##[1:20] bcw_req)
    else $error("no second word cycle after retain");
  a_mode_excl: assert property (!(io_read && io_write))
    else $error("read and write mode together");
  c_retain: cover property ($rose(retain_pri));
  c_store: cover property ($rose(sb_we));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind cie_channel_exit cie_exit_props #(.AW(AW)) u_props (.mclk(mclk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bcw_req(bcw_req),
  .bdw_req(bdw_req), .bcw_grant(bcw_grant), .bdw_grant(bdw_grant), .sb_we(sb_we),
  .retain_pri(retain_pri), .mar_drive(mar_drive), .io_write(io_write), .io_read(io_read));
`default_nettype wire

/* File: tb/cie_mux_model.sv */
// storage multiplexor model: grants cycles, serves and stores words
`timescale 1ns/1ps
`default_nettype none
module cie_mux_model #(
  parameter int GAP = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bcw_req,
  input wire logic bdw_req,
  input wire logic sb_we,
  input wire logic [14:0] mar_out,
  input wire logic [35:0] sb_wdata,
  output logic bcw_grant,
  output logic bdw_grant,
  output logic retain_pri,
  output logic [35:0] sb_data,
  output logic [14:0] mux_addr
);
  localparam logic [4:0] LEN = 5'(14 + GAP);
  logic [35:0] mem [0:127];
  logic [35:0] word;
  logic [14:0] adr;
  logic [14:0] nxt;
  logic [4:0] left;
  logic ret;
  // retained cycles fetch from the address routed back, not the channel's
  assign nxt = ret ? word[14:0] : mar_out;
  assign mux_addr = word[14:0];
  assign retain_pri = ret && left > GAP;
  // outside a cycle the bus shows the inverse so stale data never looks valid
  assign sb_data = (left > GAP) ? word : ~word;
  initial for (int i = 0; i < 128; i++) mem[i] = 36'h0;
  // one cycle at a time; GAP adds idle clocks so the channel also sees slow grants
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bcw_grant <= 1'b0;
      bdw_grant <= 1'b0;
      left <= 5'h00;
      ret <= 1'b0;
      word <= 36'h0;
      adr <= 15'h0;
    end else begin
      bcw_grant <= 1'b0;
      bdw_grant <= 1'b0;
      if (left != 5'h00) left <= left - 5'h01;
      if (sb_we) mem[adr[6:0]] <= sb_wdata;
      if (left == 5'h00 && !bcw_grant && !bdw_grant && (bcw_req || bdw_req)) begin
        adr <= nxt;
        word <= mem[nxt[6:0]];
        left <= LEN;
        bcw_grant <= bcw_req;
        bdw_grant <= !bcw_req;
        // transfer seen on S,1,2 alone, indirect on position 18
        ret <= bcw_req && (mem[nxt[6:0]][35:33] == 3'h4 || mem[nxt[6:0]][17]);
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/cie_channel_exit_tb_top.sv */
// self-checking bench for the channel exit block
`timescale 1ns/1ps
`default_nettype none
`include "cie_consts.vh"
module cie_channel_exit_tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic adp_attention = 1'b0;
  logic adp_word_taken = 1'b0;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire [35:0] sb_data, sb_wdata, adp_wdata;
  wire [14:0] mux_addr, mar_out;
  wire avs_waitrequest, bcw_req, bdw_req, bcw_grant, bdw_grant;
  wire sb_we, retain_pri, mar_drive, io_write, io_read;
  int fails = 0;
  int checks = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  // adapter read path tied off: only attention and write-side word takes are driven here
  cie_channel_exit i_cie_channel_exit (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bcw_req(bcw_req), .bdw_req(bdw_req),
    .bcw_grant(bcw_grant), .bdw_grant(bdw_grant), .sb_data(sb_data), .sb_wdata(sb_wdata),
    .sb_we(sb_we), .retain_pri(retain_pri), .mux_addr(mux_addr), .mar_out(mar_out),
    .mar_drive(mar_drive), .adp_demand(1'b0), .adp_word_taken(adp_word_taken),
    .adp_attention(adp_attention), .adp_data(36'h0), .adp_wdata(adp_wdata),
    .io_write(io_write), .io_read(io_read));
  cie_mux_model #(.GAP(2)) i_cie_mux_model (.mclk(mclk), .rstn(rstn), .bcw_req(bcw_req),
    .bdw_req(bdw_req), .sb_we(sb_we), .mar_out(mar_out), .sb_wdata(sb_wdata),
    .bcw_grant(bcw_grant), .bdw_grant(bdw_grant), .retain_pri(retain_pri),
    .sb_data(sb_data), .mux_addr(mux_addr));
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus transfer held until waitrequest is seen low
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    // sampled at each rising edge; unbounded, so only the watchdog ends a stuck wait
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus wait cycles", 36'h2, {4'h0, n});
  endtask
  task rd(input logic [4:0] a);
    bus(a, 1'b0, 32'h0, 4'hf);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(a, 1'b1, d, be);
  endtask
  // polls a register until the masked value matches, bounded
  task poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v, input string nm);
    int n;
    n = 0;
    rd(a);
    while ((q & m) !== v && n < 300) begin
      rd(a);
      n++;
    end
    chk(nm, {4'h0, v}, {4'h0, q & m});
  endtask
  task ld(input logic [6:0] a, input logic [4:0] op, input logic [14:0] ad);
    i_cie_mux_model.mem[a] = {op[4:1], 14'h0, 1'b0, op[0], 1'b0, ad};
  endtask
  task rst;
    rstn <= 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
  endtask
  task t_regs;
    rd(`CIE_OFS_STATUS);
    chk("status reset", 36'h8000, {4'h0, q}); // only the idle state bit
    rd(5'h14);
    chk("unmapped read", 36'h0, {4'h0, q});
    wr(`CIE_OFS_MODE, 32'h2a, 4'he);
    wr(5'h18, 32'h7f, 4'hf);
    rd(`CIE_OFS_MODE);
    chk("mode ignored writes", 36'h0, {29'h0, q[6:0]});
    wr(`CIE_OFS_MODE, 32'h55, 4'hf);
    rd(`CIE_OFS_MODE);
    chk("mode write", 36'h55, {29'h0, q[6:0]});
    adp_attention <= 1'b1;
    poll(`CIE_OFS_STATUS, 32'h4, 32'h4, "attention set");
    wr(`CIE_OFS_STATUS, 32'h4, 4'hf);
    poll(`CIE_OFS_STATUS, 32'h4, 32'h0, "attention cleared");
    adp_attention <= 1'b0;
    $display("test regs done");
  endtask
  task t_leave_interrupt_jump_cmd;
    ld(7'h10, 5'h11, 15'h30);
    ld(7'h30, 5'h10, 15'h30);
    wr(`CIE_OFS_START, 32'h10, 4'hf);
    poll(`CIE_OFS_COUNT, 32'h7fff, 32'h30, "cc after jump");
    poll(`CIE_OFS_STATUS, 32'h22, 32'h0, "no check after jump");
    $display("test leave and jump done");
  endtask
  task t_seq;
    // a copy with no control ahead of it is out of order on purpose
    ld(7'h10, `CIE_OP_COPY_PROCEED_CMD, 15'h0);
    ld(7'h11, 5'h10, 15'h11);
    ld(7'h23, `CIE_OP_LIP, 15'h0);
    wr(`CIE_OFS_START, 32'h10, 4'hf);
    poll(`CIE_OFS_STATUS, 32'h22, 32'h22, "check interrupt");
    poll(`CIE_OFS_STATUS, 32'h22, 32'h0, "leave clears");
    poll(`CIE_OFS_COUNT, 32'h7fff, 32'h11, "cc restored");
    chk("saved cc", 36'h11, i_cie_mux_model.mem[7'h22]);
    $display("test leave interrupt done");
  endtask
  task t_icc;
    int n;
    wr(`CIE_OFS_MODE, 32'h2b, 4'hf);
    ld(7'h10, `CIE_OP_ICC, 15'h0);
    ld(7'h11, `CIE_OP_SAR, 15'h50);
    ld(7'h12, 5'h10, 15'h12);
    wr(`CIE_OFS_START, 32'h10, 4'hf);
    poll(`CIE_OFS_COUNT, 32'h7fff, 32'h12, "cc after store");
    for (n = 0; n < 200 && i_cie_mux_model.mem[7'h50][6:0] !== 7'h2b; n++)
      @(posedge mclk);
    chk("assembly copy", 36'h2b, {29'h0, adp_wdata[6:0]});
    chk("stored copy", 36'h2b, {29'h0, i_cie_mux_model.mem[7'h50][6:0]});
    $display("test insert count done");
  endtask
  // write copy kept busy by a counting self-jump; two quick takes lose a word
  task t_wr;
    ld(7'h10, `CIE_OP_CONTROL_WRITE_CMD, 15'h0);
    ld(7'h11, `CIE_OP_COPY_PROCEED_CMD, 15'h0);
    i_cie_mux_model.mem[7'h12] = 36'h2_fffc_0012;
    wr(`CIE_OFS_START, 32'h10, 4'hf);
    poll(`CIE_OFS_STATUS, 32'h20b, 32'h208, "write refill");
    chk("write pins", 36'h1, {34'h0, io_read, io_write});
    adp_word_taken <= 1'b1;
    repeat (4) @(posedge mclk);
    adp_word_taken <= 1'b0;
    chk("assembly word", 36'h2_fffc_0012, adp_wdata);
    repeat (4) @(posedge mclk);
    adp_word_taken <= 1'b1;
    poll(`CIE_OFS_STATUS, 32'h1, 32'h1, "lost write data");
    poll(`CIE_OFS_STATUS, 32'h20, 32'h20, "check interrupt");
    adp_word_taken <= 1'b0;
    $display("test write check done");
  endtask
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim;
  end
  initial begin
    rst;
    t_regs;
    rst;
    t_leave_interrupt_jump_cmd;
    rst;
    t_seq;
    rst;
    t_icc;
    rst;
    t_wr;
    end_sim;
  end
endmodule
`default_nettype wire
